// ==== src/balu.sv ====
/*
  Byte arithmetic and logic unit: one request per clock for byte
  operations, two clocks for the word add and subtract with immediate.
  Assumes the decoder holds req stable while req_valid is high and
  req_ready is low, and that the register file writes res.lo (and res.hi
  when res.wide) back in the cycle res_valid is high.
*/
// Summary of operation
// - add and add-with-carry write the sum and set Z,C,N,V,H in one clock.
// - word add of an immediate writes both halves and sets Z,C,N,V,S in two clocks.
// - word subtract of an immediate writes both halves and sets Z,C,N,V,S in two clocks.
// - difference_imm subtracts the immediate, sets Z,C,N,V,H, one clock.
// - subtract and difference_borrow_in subtract source (and carry), Z,C,N,V,H, one clock.
// - difference_borrow_imm subtracts immediate and carry, Z,C,N,V,H, one clock.
// - and with register or immediate sets only Z,N,V in one clock.
// - or with register or immediate and exclusive or with register set Z,N,V in one clock.
// - mask_set_bits sets the masked bits and sets Z,N,V in one clock.
// - mask_clear_bits ands with all-ones minus the mask, Z,N,V, one clock.
// - zero_sign_check keeps the value and sets Z,N,V in one clock.
`include "balu_defines.svh"

module balu (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input balu_pkg::balu_req_t req,
  output logic res_valid,
  output balu_pkg::balu_res_t res,
  output balu_pkg::balu_flags_t flags
);

  // shared adder/subtractor with carry out, half carry and overflow
  function automatic balu_pkg::balu_ar_t arith(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin,
    input logic sub
  );
    logic [8:0] full;
    logic [4:0] nib;
    balu_pkg::balu_ar_t o;
    if (sub) begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      o.v = (a[7] & ~b[7] & ~full[7]) | (~a[7] & b[7] & full[7]);
    end else begin
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      o.v = (a[7] & b[7] & ~full[7]) | (~a[7] & ~b[7] & full[7]);
    end
    o.r = full[7:0];
    o.c = full[8];
    o.h = nib[4];
    return o;
  endfunction

  balu_pkg::balu_state_t state;
  logic take;
  logic is_word;
  logic is_logic;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic op_cin;
  logic op_sub;
  logic use_ar;
  logic [7:0] lg;
  logic [5:0] upd;
  logic fix_c;
  balu_pkg::balu_ar_t ar;
  logic [7:0] next_lo;
  balu_pkg::balu_flags_t cand;
  balu_pkg::balu_flags_t next_flags;
  logic [7:0] word_lo;
  logic [7:0] word_hi_src;
  logic word_c;
  logic word_sub;
  logic word_lo_zero;
  balu_pkg::balu_ar_t har;
  balu_pkg::balu_flags_t word_flags;

  // no new request while the high half of a word op is pending
  assign req_ready = (state == balu_pkg::BALU_IDLE);
  assign take = req_valid && req_ready;
  assign is_word = (req.op == balu_pkg::BALU_WORD_PLUS_IMM) ||
                   (req.op == balu_pkg::BALU_WORD_MINUS_IMM);

  // logic forms bypass the adder, so half carry stays untouched, and carry too except for the complement
  assign is_logic = req.op inside {balu_pkg::BALU_CONJ, balu_pkg::BALU_CONJ_IMM,
    balu_pkg::BALU_DISJ, balu_pkg::BALU_DISJ_IMM, balu_pkg::BALU_BITWISE_XDISJ,
    balu_pkg::BALU_BIT_INVERT, balu_pkg::BALU_MASK_SET_BITS,
    balu_pkg::BALU_MASK_CLEAR_BITS, balu_pkg::BALU_ZERO_SIGN_CHECK};

  // operand selection per byte operation
  always_comb begin
    op_a = req.dst;
    op_b = req.src;
    op_cin = 1'b0;
    op_sub = 1'b0;
    use_ar = 1'b1;
    lg = req.dst;
    upd = `BALU_UPD_ARITH;
    fix_c = 1'b0;
    case (req.op)
      balu_pkg::BALU_ADD: op_cin = 1'b0;
      balu_pkg::BALU_ADD_C: op_cin = flags.c;
      balu_pkg::BALU_SUB, balu_pkg::BALU_DIFFERENCE_BORROW_IN: begin
        op_sub = 1'b1;
        op_cin = (req.op == balu_pkg::BALU_DIFFERENCE_BORROW_IN) && flags.c;
      end
      balu_pkg::BALU_DIFFERENCE_IMM, balu_pkg::BALU_DIFFERENCE_BORROW_IMM: begin
        op_b = req.imm;
        op_sub = 1'b1;
        op_cin = (req.op == balu_pkg::BALU_DIFFERENCE_BORROW_IMM) && flags.c;
      end
      balu_pkg::BALU_CONJ: lg = req.dst & req.src;
      balu_pkg::BALU_CONJ_IMM: lg = req.dst & req.imm;
      balu_pkg::BALU_DISJ: lg = req.dst | req.src;
      balu_pkg::BALU_DISJ_IMM: lg = req.dst | req.imm;
      balu_pkg::BALU_BITWISE_XDISJ: lg = req.dst ^ req.src;
      balu_pkg::BALU_MASK_SET_BITS: lg = req.dst | req.imm;
      balu_pkg::BALU_MASK_CLEAR_BITS: lg = req.dst & (`BALU_ALL_ONES - req.imm);
      balu_pkg::BALU_ZERO_SIGN_CHECK: lg = req.dst & req.dst;
      balu_pkg::BALU_BIT_INVERT: begin
        lg = `BALU_ALL_ONES - req.dst;
        fix_c = 1'b1;
      end
      balu_pkg::BALU_SIGN_FLIP: begin
        op_a = `BALU_ZERO;
        op_b = req.dst;
        op_sub = 1'b1;
      end
      balu_pkg::BALU_PLUS_ONE, balu_pkg::BALU_MINUS_ONE: begin
        op_b = `BALU_ONE;
        op_sub = (req.op == balu_pkg::BALU_MINUS_ONE);
        upd = `BALU_UPD_LOGIC;
      end
      // word ops take their low half here, flags written later
      balu_pkg::BALU_WORD_PLUS_IMM, balu_pkg::BALU_WORD_MINUS_IMM: begin
        op_b = req.imm;
        op_sub = (req.op == balu_pkg::BALU_WORD_MINUS_IMM);
        upd = 6'h00;
      end
      default: upd = 6'h00;
    endcase
    // logic forms write z, n, v only (plus c for the complement)
    if (is_logic) begin
      use_ar = 1'b0;
      upd = fix_c ? `BALU_UPD_COMPL : `BALU_UPD_LOGIC;
    end
  end

  // candidate flags from the byte result
  always_comb begin
    ar = arith(op_a, op_b, op_cin, op_sub);
    next_lo = use_ar ? ar.r : lg;
    cand.z = (next_lo == `BALU_ZERO);
    cand.n = next_lo[7];
    cand.v = use_ar ? ar.v : 1'b0;
    cand.s = cand.n ^ cand.v;
    cand.h = ar.h;
    cand.c = fix_c | ar.c;
    if (req.op == balu_pkg::BALU_SIGN_FLIP) begin
      // borrow whenever the operand was non zero
      cand.c = (req.dst != `BALU_ZERO);
    end
    next_flags = balu_pkg::balu_flags_t'((cand & upd) | (flags & ~upd));
  end

  // high half of a word op, carry chained from the low half
  always_comb begin
    har = arith(word_hi_src, `BALU_ZERO, word_c, word_sub);
    word_flags.z = word_lo_zero && (har.r == `BALU_ZERO);
    word_flags.n = har.r[7];
    word_flags.v = har.v;
    word_flags.s = har.r[7] ^ har.v;
    word_flags.c = har.c;
    word_flags.h = flags.h;
  end

  // sequencing of the two-clock word ops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= balu_pkg::BALU_IDLE;
    end else begin
      case (state)
        balu_pkg::BALU_IDLE: begin
          if (take && is_word) begin
            state <= balu_pkg::BALU_WORD_HI;
          end
        end
        balu_pkg::BALU_WORD_HI: begin
          state <= balu_pkg::BALU_IDLE;
        end
        default: begin
          state <= balu_pkg::BALU_IDLE;
        end
      endcase
    end
  end

  // low half and carry kept for the second clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_lo <= 8'h00;
      word_hi_src <= 8'h00;
      word_c <= 1'b0;
      word_sub <= 1'b0;
      word_lo_zero <= 1'b0;
    end else if (take && is_word) begin
      word_lo <= ar.r;
      word_hi_src <= req.dst_hi;
      word_c <= ar.c;
      word_sub <= op_sub;
      word_lo_zero <= (ar.r == `BALU_ZERO);
    end
  end

  // result register, valid one clock after the last clock of the op
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      res_valid <= 1'b0;
      res <= '0;
    end else if (state == balu_pkg::BALU_WORD_HI) begin
      res_valid <= 1'b1;
      res.lo <= word_lo;
      res.hi <= har.r;
      res.wide <= 1'b1;
    end else if (take && !is_word) begin
      res_valid <= 1'b1;
      res.lo <= next_lo;
      res.hi <= 8'h00;
      res.wide <= 1'b0;
    end else begin
      res_valid <= 1'b0;
    end
  end

  // status flags; untouched bits hold so a later borrow op sees them
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flags <= balu_pkg::balu_flags_t'(`BALU_FLAGS_RST);
    end else if (state == balu_pkg::BALU_WORD_HI) begin
      flags <= balu_pkg::balu_flags_t'((word_flags & `BALU_UPD_WORD) |
                                       (flags & ~`BALU_UPD_WORD));
    end else if (take) begin
      flags <= next_flags;
    end
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_take(balu_pkg::balu_op_t o);
    req_valid && req_ready && req.op == o;
  endsequence

  chk_add_sum: assert property (
    s_take(balu_pkg::BALU_ADD) |=> res_valid &&
      {flags.c, res.lo} == 9'({1'b0, $past(req.dst)} + {1'b0, $past(req.src)}))
    else $error("add result or carry wrong");

  chk_word_add: assert property (
    s_take(balu_pkg::BALU_WORD_PLUS_IMM) |=> !res_valid && !req_ready ##1
      res_valid && res.wide && {res.hi, res.lo} ==
      16'({$past(req.dst_hi, 2), $past(req.dst, 2)} + {8'h00, $past(req.imm, 2)}))
    else $error("word add wrong or not two clocks");

  chk_word_sub: assert property (
    s_take(balu_pkg::BALU_WORD_MINUS_IMM) |=> !res_valid ##1 res_valid &&
      {res.hi, res.lo} ==
      16'({$past(req.dst_hi, 2), $past(req.dst, 2)} - {8'h00, $past(req.imm, 2)}))
    else $error("word subtract wrong");

  chk_diff_imm: assert property (
    s_take(balu_pkg::BALU_DIFFERENCE_IMM) |=> res_valid &&
      {flags.c, res.lo} == 9'({1'b0, $past(req.dst)} - {1'b0, $past(req.imm)}))
    else $error("immediate subtract wrong");

  chk_borrow_in: assert property (
    s_take(balu_pkg::BALU_DIFFERENCE_BORROW_IN) |=> res_valid &&
      res.lo == 8'($past(req.dst) - $past(req.src) - {7'h00, $past(flags.c)}))
    else $error("subtract with borrow wrong");

  chk_borrow_imm: assert property (
    s_take(balu_pkg::BALU_DIFFERENCE_BORROW_IMM) |=> res_valid &&
      res.lo == 8'($past(req.dst) - $past(req.imm) - {7'h00, $past(flags.c)}))
    else $error("immediate subtract with borrow wrong");

  chk_conj_flags: assert property (
    s_take(balu_pkg::BALU_CONJ) |=> res.lo == ($past(req.dst) & $past(req.src)) &&
      !flags.v && $stable(flags.c) && $stable(flags.h))
    else $error("and result or flags wrong");

  chk_xdisj_zero: assert property (
    s_take(balu_pkg::BALU_BITWISE_XDISJ) |=> res.lo == ($past(req.dst) ^ $past(req.src))
      && flags.z == (res.lo == 8'h00) && flags.n == res.lo[7])
    else $error("exclusive or result or flags wrong");

  chk_mask_set: assert property (
    s_take(balu_pkg::BALU_MASK_SET_BITS) |=> res.lo == ($past(req.dst) | $past(req.imm)))
    else $error("bit set wrong");

  chk_mask_clear: assert property (
    s_take(balu_pkg::BALU_MASK_CLEAR_BITS) |=>
      res.lo == ($past(req.dst) & ~$past(req.imm)) && !flags.v)
    else $error("bit clear wrong");

  chk_zero_sign: assert property (
    s_take(balu_pkg::BALU_ZERO_SIGN_CHECK) |=> res.lo == $past(req.dst) &&
      flags.n == $past(req.dst[7]) && flags.z == ($past(req.dst) == 8'h00))
    else $error("test flags wrong");

  chk_invert_neg: assert property (
    s_take(balu_pkg::BALU_BIT_INVERT) |=> res.lo == ~$past(req.dst) && flags.c)
    else $error("complement wrong");

  chk_sign_bit: assert property (
    res_valid && res.wide |-> flags.s == (flags.n ^ flags.v) && flags.n == res.hi[7] &&
      flags.z == ({res.hi, res.lo} == 16'h0000))
    else $error("word sign flag wrong");

endmodule

// ==== src/balu_defines.svh ====
/*
  Constants of the byte arithmetic and logic unit: flag reset value,
  flag update masks, the all-ones byte and the cycle counts.
  Assumes the flag vector order {h, s, v, n, z, c} of balu_flags_t.
*/
`ifndef BALU_DEFINES_SVH
`define BALU_DEFINES_SVH

// flags after reset
`define BALU_FLAGS_RST 6'h00

// which flags an operation class writes, order {h,s,v,n,z,c}
`define BALU_UPD_ARITH 6'h2f
`define BALU_UPD_LOGIC 6'h0e
`define BALU_UPD_COMPL 6'h0f
`define BALU_UPD_WORD 6'h1f

// all-ones byte used by complement and bit clear
`define BALU_ALL_ONES 8'hff
`define BALU_ONE 8'h01
`define BALU_ZERO 8'h00

// clocks per operation
`define BALU_CYC_BYTE 1
`define BALU_CYC_WORD 2

`endif

// ==== src/balu_pkg.sv ====
/*
  Types of the byte arithmetic and logic unit: operation codes, states,
  flag vector, request and result carriers.
  Assumes the decoder drives a balu_req_t and reads a balu_res_t.
*/
package balu_pkg;

  typedef enum logic [4:0] {
    BALU_ADD = 5'h00,
    BALU_ADD_C = 5'h01,
    BALU_WORD_PLUS_IMM = 5'h02,
    BALU_SUB = 5'h03,
    BALU_DIFFERENCE_IMM = 5'h04,
    BALU_DIFFERENCE_BORROW_IN = 5'h05,
    BALU_DIFFERENCE_BORROW_IMM = 5'h06,
    BALU_WORD_MINUS_IMM = 5'h07,
    BALU_CONJ = 5'h08,
    BALU_CONJ_IMM = 5'h09,
    BALU_DISJ = 5'h0a,
    BALU_DISJ_IMM = 5'h0b,
    BALU_BITWISE_XDISJ = 5'h0c,
    BALU_BIT_INVERT = 5'h0d,
    BALU_SIGN_FLIP = 5'h0e,
    BALU_MASK_SET_BITS = 5'h0f,
    BALU_MASK_CLEAR_BITS = 5'h10,
    BALU_PLUS_ONE = 5'h11,
    BALU_MINUS_ONE = 5'h12,
    BALU_ZERO_SIGN_CHECK = 5'h13
  } balu_op_t;

  typedef enum logic [0:0] {
    BALU_IDLE = 1'b0,
    BALU_WORD_HI = 1'b1
  } balu_state_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } balu_flags_t;

  typedef struct packed {
    balu_op_t op;
    logic [7:0] dst;
    logic [7:0] dst_hi;
    logic [7:0] src;
    logic [7:0] imm;
  } balu_req_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic wide;
  } balu_res_t;

  typedef struct packed {
    logic c;
    logic h;
    logic v;
    logic [7:0] r;
  } balu_ar_t;

endpackage

// ==== bench/balu_dec_model.sv ====
/*
  Decoder-side model of the byte arithmetic and logic unit: queued
  requests go out one at a time and each is held until it is taken.
  Assumes the unit takes req at a rising edge while req_ready is high.
*/
module balu_dec_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  input wire logic req_ready,
  output logic req_valid,
  output balu_pkg::balu_req_t req,
  output logic took
);
  timeunit 1ns;
  timeprecision 1ps;

  balu_pkg::balu_req_t pend[$];

  initial begin
    req_valid = 1'b0;
    req = '0;
    took = 1'b0;
  end

  // remember whether the last rising edge took the request on offer
  always @(posedge clk_sys) begin
    took <= resetn && req_valid && req_ready;
  end

  // change only at the falling edge; a released bus shows the inverse,
  // so stale data never looks like a fresh request
  always @(negedge clk_sys) begin
    if (took || !req_valid) begin
      if (pend.size() > 0 && !(took && slow)) begin
        req <= pend.pop_front();
        req_valid <= 1'b1;
      end else begin
        req <= ~req;
        req_valid <= 1'b0;
      end
    end
  end

  task automatic push(input balu_pkg::balu_req_t r);
    pend.push_back(r);
  endtask
endmodule

// ==== bench/tb.sv ====
/*
  Self-checking bench of the byte arithmetic and logic unit: a model
  built from integers predicts every result, its flags and its timing.
  Assumes the decoder model drives all requests at the falling edge.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] lo;
    logic [7:0] hi;
    logic wide;
    logic [5:0] fl;
    int due;
  } balu_exp_t;

  logic clk_sys;
  logic resetn;
  logic slow;
  logic req_valid;
  logic req_ready;
  logic res_valid;
  logic took;
  balu_pkg::balu_req_t req;
  balu_pkg::balu_res_t res;
  balu_pkg::balu_flags_t flags;
  logic fh, fs, fv, fn, fz, fc;
  logic [31:0] rnd;
  int fail_count = 0;
  int check_count = 0;
  int nc = 0;
  int seed = 82;
  balu_exp_t eq[$];
  balu_exp_t cur;

  balu u_balu (.clk_sys, .resetn, .req_valid, .req_ready, .req, .res_valid, .res, .flags);
  balu_dec_model u_dec (.clk_sys, .resetn, .slow, .req_ready, .req_valid, .req, .took);

  // 25 MHz core clock
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // byte add or subtract with carry in; sets h, v, n, z, c
  function automatic logic [7:0] arith(input int a, input int b, input int ci, input bit sub);
    int t;
    logic [7:0] y;
    t = sub ? a - b - ci : a + b + ci;
    y = t[7:0];
    fc = sub ? (a < b + ci) : (t > 255);
    fh = sub ? ((a & 15) < (b & 15) + ci) : ((a & 15) + (b & 15) + ci > 15);
    fv = sub ? (a[7] != b[7] && y[7] != a[7]) : (a[7] == b[7] && y[7] != a[7]);
    fn = y[7];
    fz = (y == 8'h00);
    return y;
  endfunction

  // result with z, n and a given v
  function automatic logic [7:0] lg(input logic [7:0] y, input bit v);
    fv = v;
    fn = y[7];
    fz = (y == 8'h00);
    return y;
  endfunction

  function automatic void model(input balu_pkg::balu_req_t r);
    logic [15:0] w;
    int t;
    balu_exp_t e;
    e.hi = 8'h00;
    e.wide = 1'b0;
    e.due = nc;
    case (r.op)
      balu_pkg::BALU_ADD: e.lo = arith(r.dst, r.src, 0, 1'b0);
      balu_pkg::BALU_ADD_C: e.lo = arith(r.dst, r.src, fc, 1'b0);
      balu_pkg::BALU_SUB: e.lo = arith(r.dst, r.src, 0, 1'b1);
      balu_pkg::BALU_DIFFERENCE_IMM: e.lo = arith(r.dst, r.imm, 0, 1'b1);
      balu_pkg::BALU_DIFFERENCE_BORROW_IN: e.lo = arith(r.dst, r.src, fc, 1'b1);
      balu_pkg::BALU_DIFFERENCE_BORROW_IMM: e.lo = arith(r.dst, r.imm, fc, 1'b1);
      balu_pkg::BALU_SIGN_FLIP: e.lo = arith(0, r.dst, 0, 1'b1);
      balu_pkg::BALU_CONJ: e.lo = lg(r.dst & r.src, 1'b0);
      balu_pkg::BALU_CONJ_IMM: e.lo = lg(r.dst & r.imm, 1'b0);
      balu_pkg::BALU_DISJ: e.lo = lg(r.dst | r.src, 1'b0);
      balu_pkg::BALU_DISJ_IMM, balu_pkg::BALU_MASK_SET_BITS: e.lo = lg(r.dst | r.imm, 1'b0);
      balu_pkg::BALU_BITWISE_XDISJ: e.lo = lg(r.dst ^ r.src, 1'b0);
      balu_pkg::BALU_MASK_CLEAR_BITS: e.lo = lg(r.dst & (8'hff - r.imm), 1'b0);
      balu_pkg::BALU_ZERO_SIGN_CHECK: e.lo = lg(r.dst & r.dst, 1'b0);
      balu_pkg::BALU_PLUS_ONE: e.lo = lg(r.dst + 8'h01, r.dst == 8'h7f);
      balu_pkg::BALU_MINUS_ONE: e.lo = lg(r.dst - 8'h01, r.dst == 8'h80);
      balu_pkg::BALU_BIT_INVERT: begin
        e.lo = lg(8'hff - r.dst, 1'b0);
        fc = 1'b1;
      end
      default: begin
        // word ops: 16-bit pair with zero-extended immediate, h untouched
        w = {r.dst_hi, r.dst};
        t = (r.op == balu_pkg::BALU_WORD_PLUS_IMM) ? w + r.imm : w - r.imm;
        {e.hi, e.lo} = t[15:0];
        fc = (t > 65535) || (t < 0);
        fn = e.hi[7];
        fv = (r.op == balu_pkg::BALU_WORD_PLUS_IMM) ? (!w[15] && fn) : (w[15] && !fn);
        fz = (t[15:0] == 16'h0000);
        fs = fn ^ fv;
        e.wide = 1'b1;
        e.due = nc + 1;
      end
    endcase
    e.fl = {fh, fs, fv, fn, fz, fc};
    eq.push_back(e);
  endfunction

  // predict at each take, compare at each result, in issue order
  always @(negedge clk_sys) begin
    nc++;
    if (took === 1'b1) begin
      if (req.op inside {balu_pkg::BALU_WORD_PLUS_IMM, balu_pkg::BALU_WORD_MINUS_IMM}) begin
        chk("ready after word take", req_ready, 17'h0);
      end
      model(req);
    end
    if (res_valid === 1'b1) begin
      if (eq.size() == 0) begin
        chk("unexpected result", 17'h1, 17'h0);
      end else begin
        cur = eq.pop_front();
        chk("result cycle", 17'(nc), 17'(cur.due));
        chk("res.lo", res.lo, cur.lo);
        chk("res.wide", res.wide, cur.wide);
        if (cur.wide) begin
          chk("res.hi", res.hi, cur.hi);
        end
        chk("flags", flags, cur.fl);
      end
    end
  end

  task automatic q(input balu_pkg::balu_op_t op, input logic [7:0] d, input logic [7:0] dh,
                   input logic [7:0] s, input logic [7:0] i);
    u_dec.push(balu_pkg::balu_req_t'{op, d, dh, s, i});
  endtask

  // bounded wait until every request is issued and answered; a stalled
  // batch of 200 needs two clocks per request, so the bound leaves room
  task automatic drain(input string name);
    int n;
    n = 0;
    while ((u_dec.pend.size() > 0 || eq.size() > 0 || req_valid) && n < 1000) begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    chk("drain timeout", 17'(n >= 1000), 17'h0);
    if (n >= 1000) begin
      close_out();
    end
    @(negedge clk_sys);
    $display("test %s done", name);
  endtask

  task automatic reset_unit();
    resetn = 1'b0;
    {fh, fs, fv, fn, fz, fc} = 6'h00;
    repeat (10) @(negedge clk_sys);
    chk("reset ready", req_ready, 17'h1);
    chk("reset res_valid", res_valid, 17'h0);
    chk("reset res", res, 17'h0);
    chk("reset flags", flags, 17'h0);
    resetn = 1'b1;
  endtask

  initial begin
    slow = 1'b0;
    reset_unit();
    $display("test reset done");
    // boundary values: carries, overflow edges, word wrap, back-to-back words
    q(balu_pkg::BALU_ADD, 8'hff, 8'h00, 8'h01, 8'h00);
    q(balu_pkg::BALU_ADD_C, 8'h7f, 8'h00, 8'h00, 8'h00);
    q(balu_pkg::BALU_SUB, 8'h00, 8'h00, 8'h01, 8'h00);
    q(balu_pkg::BALU_DIFFERENCE_BORROW_IN, 8'h10, 8'h00, 8'h0f, 8'h00);
    q(balu_pkg::BALU_WORD_PLUS_IMM, 8'hff, 8'hff, 8'h00, 8'h01);
    q(balu_pkg::BALU_WORD_MINUS_IMM, 8'h00, 8'h00, 8'h00, 8'h01);
    q(balu_pkg::BALU_DIFFERENCE_BORROW_IMM, 8'h00, 8'h00, 8'h00, 8'h00);
    q(balu_pkg::BALU_WORD_PLUS_IMM, 8'hff, 8'h7f, 8'h00, 8'h01);
    q(balu_pkg::BALU_WORD_MINUS_IMM, 8'h00, 8'h80, 8'h00, 8'h01);
    q(balu_pkg::BALU_SIGN_FLIP, 8'h80, 8'h00, 8'h00, 8'h00);
    q(balu_pkg::BALU_SIGN_FLIP, 8'h00, 8'h00, 8'h00, 8'h00);
    q(balu_pkg::BALU_PLUS_ONE, 8'h7f, 8'h00, 8'h00, 8'h00);
    q(balu_pkg::BALU_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h00);
    q(balu_pkg::BALU_BIT_INVERT, 8'hff, 8'h00, 8'h00, 8'h00);
    q(balu_pkg::BALU_MASK_CLEAR_BITS, 8'hf0, 8'h00, 8'h00, 8'h30);
    q(balu_pkg::BALU_ZERO_SIGN_CHECK, 8'h00, 8'h00, 8'h00, 8'h00);
    drain("boundaries");
    // every op once, then random mixes; the second half stalls between requests
    for (int k = 0; k < 400; k++) begin
      if (k == 200) begin
        drain("random fast");
        slow = 1'b1;
      end
      rnd = $random(seed);
      q(balu_pkg::balu_op_t'(5'((k < 20) ? k : $unsigned($random(seed)) % 20)),
        rnd[7:0], rnd[15:8], rnd[23:16], rnd[31:24]);
    end
    drain("random slow");
    // a second reset must clear the carry that the next add would use
    q(balu_pkg::BALU_ADD, 8'hff, 8'h00, 8'hff, 8'h00);
    drain("carry set");
    reset_unit();
    q(balu_pkg::BALU_ADD_C, 8'h01, 8'h00, 8'h01, 8'h00);
    drain("second reset");
    close_out();
  end
endmodule
